// *** core/arc_pkg.sv ***
// Constants, register map and carriers for the alignment request capture block.
// Assumes a single 20 MHz AHB-Lite clock domain.
package arc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ARC_IDX_SNAP_LOW  = 8'h0B;
  localparam logic [7:0] ARC_IDX_SNAP_HIGH = 8'h0C;
  localparam logic [7:0] ARC_IDX_STEP_SEL  = 8'h0D;
  localparam logic [7:0] ARC_IDX_PATH_CTRL = 8'h0E;
  localparam logic [7:0] ARC_IDX_AUX_CTRL  = 8'h10;
  localparam int         ARC_IDX_SHIFT     = 2;

  // Reset values
  localparam logic [15:0] ARC_RST_SNAP      = 16'hFFFF;
  localparam logic [1:0]  ARC_RST_STEP_CODE = 2'h3;
  localparam logic [15:0] ARC_RST_PATH_CTRL = 16'h0002;

  // Field positions of the path control register
  localparam int ARC_BIT_LATCH_EN  = 0;
  localparam int ARC_BIT_PIN_FUNC  = 1;
  localparam int ARC_BIT_CAPT_EN   = 2;
  localparam int ARC_BIT_MUTE_DIS  = 8;
  // Field positions of the auxiliary control register
  localparam int ARC_BIT_REQ_CLEAR = 0;
  localparam int ARC_BIT_SYNC_EN   = 1;
  localparam int ARC_BIT_REF_EN    = 2;

  localparam logic ARC_PIN_SYNC = 1'b0;
  localparam logic ARC_PIN_REQ  = 1'b1;

  // Snapshot geometry
  localparam int         ARC_SNAP_W    = 32;
  localparam int         ARC_HALF_W    = 16;
  localparam logic [4:0] ARC_SNAP_LAST = 5'h1F;

  // Step size in ps for codes 0..3
  localparam logic [7:0] ARC_STEP_PS [4] = '{8'h1C, 8'h0F, 8'h0B, 8'h08};
  // Delay per step in hclk cycles, coarsest step the longest
  localparam logic [1:0] ARC_STEP_CYC [4] = '{2'h3, 2'h2, 2'h1, 2'h0};

  localparam logic [1:0] ARC_HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ARC_ZERO_WORD    = 32'h0000_0000;

  typedef enum logic [1:0] {
    ARC_CAP_IDLE    = 2'b00,
    ARC_CAP_CLEARED = 2'b01,
    ARC_CAP_ARMED   = 2'b10,
    ARC_CAP_RUN     = 2'b11
  } arc_cap_state_type;

  typedef struct packed {
    logic sync_mute_disable;
    logic edge_capture_enable;
    logic request_pin_function;
    logic request_latch_enable;
  } arc_path_ctrl_type;

  typedef struct packed {
    logic request_clear;
    logic sync_path_enable;
    logic reference_pulse_enable;
  } arc_aux_ctrl_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] index;
  } arc_addr_phase_type;

endpackage : arc_pkg

// *** core/arc_sync2.sv ***
// Two-stage level synchroniser for one pin input.
// Assumes the destination clock is hclk with asynchronous active-low reset.
module arc_sync2 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  output logic      level_out
);
  logic meta_ff;
  logic hold_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      hold_ff <= meta_ff;
    end
  end

  assign level_out = hold_ff;
endmodule : arc_sync2

// *** core/arc_core.sv ***
// Alignment request capture: request path, latch, mute, edge windowing, AHB-Lite registers.
// Assumes request and input clock sample pins are asynchronous; one hclk domain.
module arc_core
  import arc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        alignment_request_input,
  input  wire logic        input_clock,
  output logic             request_state,
  output logic             request_pulse_mode,
  output logic             alignment_pulse_mute,
  output logic             clock_divider_sync,
  output logic             pulse_divider_reset,
  output logic             windowing_active,
  output logic [7:0]       request_delay_step_ps
);

  // Pin synchronisers
  logic req_sync;
  logic clk_sync;

  arc_sync2 u_req_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (alignment_request_input),
    .level_out (req_sync)
  );

  arc_sync2 u_clk_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (input_clock),
    .level_out (clk_sync)
  );

  // Register state
  arc_addr_phase_type aph_ff;
  arc_addr_phase_type nxt_aph;
  arc_path_ctrl_type  path_ff;
  arc_path_ctrl_type  nxt_path;
  arc_aux_ctrl_type   aux_ff;
  arc_aux_ctrl_type   nxt_aux;
  logic [1:0]         step_code_ff;
  logic [1:0]         nxt_step_code;
  logic [31:0]        hrdata_ff;
  logic [31:0]        nxt_hrdata;

  // Request path state
  logic [3:0]         req_line_ff;
  logic [3:0]         nxt_req_line;
  logic               req_dly_prev_ff;
  logic               nxt_req_dly_prev;
  logic               latched_ff;
  logic               nxt_latched;
  logic               state_prev_ff;
  logic               nxt_state_prev;
  logic               mute_ff;
  logic               nxt_mute;
  logic               div_sync_ff;
  logic               nxt_div_sync;

  // Capture state
  arc_cap_state_type  cap_ff;
  arc_cap_state_type  nxt_cap;
  logic [4:0]         samp_idx_ff;
  logic [4:0]         nxt_samp_idx;
  logic [1:0]         space_ff;
  logic [1:0]         nxt_space;
  logic [31:0]        work_ff;
  logic [31:0]        nxt_work;
  logic [31:0]        snap_ff;
  logic [31:0]        nxt_snap;

  logic               req_dly;
  logic               req_rise;
  logic               window_en;
  logic [1:0]         step_cyc;
  logic               state_now;

  assign step_cyc = ARC_STEP_CYC[step_code_ff];
  assign req_dly  = req_line_ff[step_cyc];
  assign req_rise = req_dly && !req_dly_prev_ff;

  assign window_en = path_ff.edge_capture_enable
                     && (aux_ff.sync_path_enable || aux_ff.reference_pulse_enable);

  assign state_now = path_ff.request_latch_enable ? (latched_ff || req_rise) : req_dly;

  // Bus register file
  always_comb begin
    nxt_aph       = aph_ff;
    nxt_path      = path_ff;
    nxt_aux       = aux_ff;
    nxt_step_code = step_code_ff;
    nxt_hrdata    = hrdata_ff;
    if (aph_ff.valid && aph_ff.write) begin
      if (aph_ff.index == ARC_IDX_STEP_SEL) begin
        nxt_step_code = hwdata[1:0];
      end else if (aph_ff.index == ARC_IDX_PATH_CTRL) begin
        nxt_path.sync_mute_disable    = hwdata[ARC_BIT_MUTE_DIS];
        nxt_path.edge_capture_enable  = hwdata[ARC_BIT_CAPT_EN];
        nxt_path.request_pin_function = hwdata[ARC_BIT_PIN_FUNC];
        nxt_path.request_latch_enable = hwdata[ARC_BIT_LATCH_EN];
      end else if (aph_ff.index == ARC_IDX_AUX_CTRL) begin
        nxt_aux.request_clear          = hwdata[ARC_BIT_REQ_CLEAR];
        nxt_aux.sync_path_enable       = hwdata[ARC_BIT_SYNC_EN];
        nxt_aux.reference_pulse_enable = hwdata[ARC_BIT_REF_EN];
      end
    end
    if (hsel && hready) begin
      nxt_aph.valid = (htrans == ARC_HTRANS_NONSEQ);
      nxt_aph.write = hwrite;
      nxt_aph.index = haddr[ARC_IDX_SHIFT +: 8];
    end else begin
      nxt_aph.valid = 1'b0;
    end
    nxt_hrdata = ARC_ZERO_WORD;
    if (hsel && hready && (htrans == ARC_HTRANS_NONSEQ) && !hwrite) begin
      if (haddr[ARC_IDX_SHIFT +: 8] == ARC_IDX_SNAP_LOW) begin
        nxt_hrdata[ARC_HALF_W-1:0] = snap_ff[ARC_HALF_W-1:0];
      end else if (haddr[ARC_IDX_SHIFT +: 8] == ARC_IDX_SNAP_HIGH) begin
        nxt_hrdata[ARC_HALF_W-1:0] = snap_ff[ARC_SNAP_W-1:ARC_HALF_W];
      end else if (haddr[ARC_IDX_SHIFT +: 8] == ARC_IDX_STEP_SEL) begin
        nxt_hrdata[1:0] = step_code_ff;
      end else if (haddr[ARC_IDX_SHIFT +: 8] == ARC_IDX_PATH_CTRL) begin
        nxt_hrdata[ARC_BIT_MUTE_DIS] = path_ff.sync_mute_disable;
        nxt_hrdata[ARC_BIT_CAPT_EN]  = path_ff.edge_capture_enable;
        nxt_hrdata[ARC_BIT_PIN_FUNC] = path_ff.request_pin_function;
        nxt_hrdata[ARC_BIT_LATCH_EN] = path_ff.request_latch_enable;
      end else if (haddr[ARC_IDX_SHIFT +: 8] == ARC_IDX_AUX_CTRL) begin
        nxt_hrdata[ARC_BIT_REQ_CLEAR] = aux_ff.request_clear;
        nxt_hrdata[ARC_BIT_SYNC_EN]   = aux_ff.sync_path_enable;
        nxt_hrdata[ARC_BIT_REF_EN]    = aux_ff.reference_pulse_enable;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff       <= '0;
      path_ff      <= '{sync_mute_disable:    ARC_RST_PATH_CTRL[ARC_BIT_MUTE_DIS],
                        edge_capture_enable:  ARC_RST_PATH_CTRL[ARC_BIT_CAPT_EN],
                        request_pin_function: ARC_RST_PATH_CTRL[ARC_BIT_PIN_FUNC],
                        request_latch_enable: ARC_RST_PATH_CTRL[ARC_BIT_LATCH_EN]};
      aux_ff       <= '0;
      step_code_ff <= ARC_RST_STEP_CODE;
      hrdata_ff    <= ARC_ZERO_WORD;
    end else begin
      aph_ff       <= nxt_aph;
      path_ff      <= nxt_path;
      aux_ff       <= nxt_aux;
      step_code_ff <= nxt_step_code;
      hrdata_ff    <= nxt_hrdata;
    end
  end

  // Request path: delay line, latch, SYNC actions
  always_comb begin
    nxt_req_line     = {req_line_ff[2:0], req_sync};
    nxt_req_dly_prev = req_dly;
    nxt_latched      = latched_ff;
    if (aux_ff.request_clear) begin
      nxt_latched = 1'b0;
    end
    // Rising edge sets latch, wins over clear
    if (path_ff.request_latch_enable && req_rise) begin
      nxt_latched = 1'b1;
    end
    if (!path_ff.request_latch_enable) begin
      nxt_latched = 1'b0;
    end
    nxt_state_prev = state_now;
    // Mute in SYNC mode unless disabled
    nxt_mute = (path_ff.request_pin_function == ARC_PIN_SYNC)
               && !path_ff.sync_mute_disable;
    // SYNC edge resets both divider sets
    nxt_div_sync = (path_ff.request_pin_function == ARC_PIN_SYNC)
                   && state_now && !state_prev_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_line_ff     <= '0;
      req_dly_prev_ff <= 1'b0;
      latched_ff      <= 1'b0;
      state_prev_ff   <= 1'b0;
      mute_ff         <= 1'b0;
      div_sync_ff     <= 1'b0;
    end else begin
      req_line_ff     <= nxt_req_line;
      req_dly_prev_ff <= nxt_req_dly_prev;
      latched_ff      <= nxt_latched;
      state_prev_ff   <= nxt_state_prev;
      mute_ff         <= nxt_mute;
      div_sync_ff     <= nxt_div_sync;
    end
  end

  // Windowing capture
  always_comb begin
    nxt_cap      = cap_ff;
    nxt_samp_idx = samp_idx_ff;
    nxt_space    = space_ff;
    nxt_work     = work_ff;
    nxt_snap     = snap_ff;
    case (cap_ff)
      ARC_CAP_IDLE: begin
        if (aux_ff.request_clear) begin
          nxt_cap = ARC_CAP_CLEARED;
        end
      end
      ARC_CAP_CLEARED: begin
        if (!aux_ff.request_clear) begin
          nxt_cap = ARC_CAP_ARMED;
        end
      end
      ARC_CAP_ARMED: begin
        if (aux_ff.request_clear) begin
          nxt_cap = ARC_CAP_CLEARED;
        end else if (req_rise) begin
          nxt_cap      = ARC_CAP_RUN;
          nxt_samp_idx = '0;
          nxt_space    = '0;
          nxt_work     = '0;
        end
      end
      ARC_CAP_RUN: begin
        // One sample per step, low bit first
        if (space_ff == step_cyc) begin
          nxt_space              = '0;
          nxt_work[samp_idx_ff]  = clk_sync;
          nxt_samp_idx           = samp_idx_ff + 5'h01;
          if (samp_idx_ff == ARC_SNAP_LAST) begin
            nxt_snap                = nxt_work;
            nxt_snap[0]             = 1'b1;
            nxt_snap[ARC_SNAP_W-1]  = 1'b1;
            nxt_cap                 = ARC_CAP_IDLE;
          end
        end else begin
          nxt_space = space_ff + 2'h1;
        end
      end
      default: begin
        nxt_cap = ARC_CAP_IDLE;
      end
    endcase
    if (!window_en) begin
      nxt_cap = ARC_CAP_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_ff      <= ARC_CAP_IDLE;
      samp_idx_ff <= '0;
      space_ff    <= '0;
      work_ff     <= '0;
      snap_ff     <= {ARC_RST_SNAP, ARC_RST_SNAP};
    end else begin
      cap_ff      <= nxt_cap;
      samp_idx_ff <= nxt_samp_idx;
      space_ff    <= nxt_space;
      work_ff     <= nxt_work;
      // Snapshot only replaced at capture end
      snap_ff     <= nxt_snap;
    end
  end

  // Outputs
  assign hreadyout             = 1'b1;
  assign hresp                 = 1'b0;
  assign hrdata                = hrdata_ff;
  assign request_state         = state_prev_ff;
  assign request_pulse_mode    = path_ff.request_pin_function;
  assign alignment_pulse_mute  = mute_ff;
  assign clock_divider_sync    = div_sync_ff;
  assign pulse_divider_reset   = div_sync_ff;
  assign windowing_active      = window_en;
  assign request_delay_step_ps = ARC_STEP_PS[step_code_ff];

endmodule : arc_core

// *** verif/arc_core_monitor.sv ***
// Port checker for arc_core: bus answer, mute, divider pulses, request and config timing.
// Assumes one hclk domain; bound onto every arc_core instance.
module arc_core_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        alignment_request_input,
  input wire logic        request_state,
  input wire logic        request_pulse_mode,
  input wire logic        alignment_pulse_mute,
  input wire logic        clock_divider_sync,
  input wire logic        pulse_divider_reset,
  input wire logic        windowing_active,
  input wire logic [7:0]  request_delay_step_ps
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel && hready && (htrans == 2'h2);
  sequence req_up;
    $rose(request_state);
  endsequence
  sequence pin_was_high;
    $past(alignment_request_input, 4) || $past(alignment_request_input, 5)
      || $past(alignment_request_input, 6) || $past(alignment_request_input, 7);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_read_idle: assert property (!(take && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data left standing");
  a_mute_reqmode: assert property (request_pulse_mode && $past(request_pulse_mode) |-> !alignment_pulse_mute)
    else $error("pulses muted in request mode");
  a_pulse_pair: assert property (pulse_divider_reset == clock_divider_sync)
    else $error("divider reset differs from divider sync");
  a_pulse_once: assert property (clock_divider_sync |=> !clock_divider_sync)
    else $error("divider sync pulse longer than one cycle");
  a_pulse_cause: assert property (clock_divider_sync |-> request_state && !request_pulse_mode)
    else $error("divider sync outside a sync request");
  a_state_cause: assert property (req_up |-> pin_was_high)
    else $error("request state rose without a pin request");
  a_cfg_by_write: assert property ($changed({windowing_active, request_pulse_mode,
    request_delay_step_ps}) |-> $past(take && hwrite, 2) || $past(take && hwrite, 3))
    else $error("configuration output changed without a write");
  a_step_legal: assert property (request_delay_step_ps inside {8'h1C, 8'h0F, 8'h0B, 8'h08})
    else $error("step size outside the four codes");
endmodule : arc_core_monitor

bind arc_core arc_core_monitor arc_core_monitor_inst (.hclk, .hresetn, .hsel, .hready, .htrans,
  .hwrite, .hreadyout, .hresp, .hrdata, .alignment_request_input, .request_state,
  .request_pulse_mode, .alignment_pulse_mute, .clock_divider_sync, .pulse_divider_reset,
  .windowing_active, .request_delay_step_ps);

// *** verif/arc_req_src.sv ***
// External request source: pulses the request pin and sets the sampled clock level.
// Assumes fire is a one-cycle strobe on hclk; lag sets how slowly it answers.
module arc_req_src (
  input  wire logic       hclk,
  input  wire logic       fire,
  input  wire logic [3:0] lag,
  input  wire logic       clk_lvl,
  output logic            alignment_request_input,
  output logic            input_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt_ff;
  initial cnt_ff = 5'h00;
  assign input_clock = clk_lvl;
  // Six-cycle request after lag
  always @(posedge hclk) begin
    if (fire) cnt_ff <= 5'(lag) + 5'h06;
    else if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
  end
  assign alignment_request_input = (cnt_ff != 5'h00) && (cnt_ff <= 5'h06);
endmodule : arc_req_src

// *** verif/tb.sv ***
// Self-checking bench for arc_core over AHB-Lite with an external request source.
// Assumes hready is looped back from hreadyout and a single slave on the bus.
module tb
  import arc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [7:0]  ps;
  } arc_row_type;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fire, clk_lvl;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  lag;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic        alignment_request_input, input_clock, request_state, request_pulse_mode;
  logic        alignment_pulse_mute, clock_divider_sync, pulse_divider_reset, windowing_active;
  logic [7:0]  request_delay_step_ps;
  int          miscompares, n_compared, k;
  arc_row_type rows [7] = '{'{ARC_IDX_STEP_SEL, 32'h0, 32'h0, 8'h1C},
    '{ARC_IDX_STEP_SEL, 32'h1, 32'h1, 8'h0F}, '{ARC_IDX_STEP_SEL, 32'h2, 32'h2, 8'h0B},
    '{ARC_IDX_STEP_SEL, 32'hFFFF_FFFF, 32'h3, 8'h08},
    '{ARC_IDX_PATH_CTRL, 32'h107, 32'h107, 8'h08},
    '{ARC_IDX_SNAP_HIGH, 32'h0, 32'hFFFF, 8'h08}, '{8'h20, 32'h5, 32'h0, 8'h08}};

  arc_core arc_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .alignment_request_input, .input_clock,
    .request_state, .request_pulse_mode, .alignment_pulse_mute, .clock_divider_sync,
    .pulse_divider_reset, .windowing_active, .request_delay_step_ps);
  arc_req_src arc_req_src_inst (.hclk, .fire, .lag, .clk_lvl, .alignment_request_input,
    .input_clock);

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= ARC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= 32'(idx) << ARC_IDX_SHIFT;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    bus(1'b0, idx, 32'h0);
    chk(nm, rdv, exp);
  endtask : rd

  task automatic fire_req(input logic [3:0] l);
    lag <= l;
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
  endtask : fire_req

  task automatic arm_capture();
    bus(1'b1, ARC_IDX_AUX_CTRL, 32'h3);
    bus(1'b1, ARC_IDX_AUX_CTRL, 32'h2);
  endtask : arm_capture

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  initial begin
    #250000;
    miscompares++;
    test_done();
  end

  initial begin
    {hresetn, hsel, hwrite, fire, clk_lvl, htrans, lag} = '0;
    {haddr, hwdata, miscompares, n_compared} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    chk("rst_out", {request_pulse_mode, alignment_pulse_mute, windowing_active,
      request_state, request_delay_step_ps}, {4'b1000, 8'h08});
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ARC_IDX_STEP_SEL, 32'h3, "step_rst");
    rd(ARC_IDX_PATH_CTRL, 32'h2, "path_rst");
    rd(ARC_IDX_SNAP_HIGH, 32'hFFFF, "snap_rst");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].rd, "row_read");
      chk("row_step_ps", request_delay_step_ps, rows[i].ps);
    end
    // SYNC mode with mute enabled: all path bits written as zero
    bus(1'b1, ARC_IDX_PATH_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    chk("mute_sync", alignment_pulse_mute, 1'b1);
    chk("mode_sync", request_pulse_mode, 1'b0);
    fire_req(4'h3);
    for (k = 0; k < 40 && clock_divider_sync !== 1'b1; k++) @(posedge hclk);
    chk("div_sync", clock_divider_sync, 1'b1);
    chk("div_reset", pulse_divider_reset, 1'b1);
    bus(1'b1, ARC_IDX_PATH_CTRL, 32'h100);
    repeat (2) @(posedge hclk);
    chk("mute_off", alignment_pulse_mute, 1'b0);
    bus(1'b1, ARC_IDX_STEP_SEL, 32'h0);
    bus(1'b1, ARC_IDX_PATH_CTRL, 32'h3);
    fire_req(4'h5);
    repeat (30) @(posedge hclk);
    chk("latched", request_state, 1'b1);
    bus(1'b1, ARC_IDX_AUX_CTRL, 32'h1);
    repeat (3) @(posedge hclk);
    chk("released", request_state, 1'b0);
    bus(1'b1, ARC_IDX_PATH_CTRL, 32'h2);
    fire_req(4'h0);
    repeat (9) @(posedge hclk);
    chk("bypass_pass", request_state, 1'b1);
    repeat (21) @(posedge hclk);
    chk("bypassed", request_state, 1'b0);
    // step picked for the clock range
    bus(1'b1, ARC_IDX_STEP_SEL, 32'h3);
    bus(1'b1, ARC_IDX_PATH_CTRL, 32'h6);
    bus(1'b1, ARC_IDX_AUX_CTRL, 32'h0);
    @(posedge hclk);
    chk("win_off", windowing_active, 1'b0);
    bus(1'b1, ARC_IDX_AUX_CTRL, 32'h4);
    @(posedge hclk);
    chk("win_ref", windowing_active, 1'b1);
    arm_capture();
    fire_req(4'h2);
    repeat (200) @(posedge hclk);
    rd(ARC_IDX_SNAP_HIGH, 32'h8000, "snap_hi_low");
    rd(ARC_IDX_SNAP_LOW, 32'h0001, "snap_lo_low");
    clk_lvl <= 1'b1;
    fire_req(4'h0);
    repeat (200) @(posedge hclk);
    rd(ARC_IDX_SNAP_HIGH, 32'h8000, "snap_held");
    arm_capture();
    fire_req(4'h1);
    repeat (200) @(posedge hclk);
    rd(ARC_IDX_SNAP_HIGH, 32'hFFFF, "snap_hi_high");
    bus(1'b1, ARC_IDX_STEP_SEL, 32'h0);
    clk_lvl <= 1'b0;
    arm_capture();
    fire_req(4'h0);
    repeat (70) @(posedge hclk);
    rd(ARC_IDX_SNAP_LOW, 32'hFFFF, "snap_pending");
    repeat (130) @(posedge hclk);
    rd(ARC_IDX_SNAP_LOW, 32'h0001, "snap_slow");
    bus(1'b1, ARC_IDX_PATH_CTRL, 32'h2);
    @(posedge hclk);
    chk("win_done", windowing_active, 1'b0);
    // Mid-run reset returns registers to defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_mid", {request_pulse_mode, request_delay_step_ps}, {1'b1, 8'h08});
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ARC_IDX_STEP_SEL, 32'h3, "step_rst_mid");
    rd(ARC_IDX_SNAP_HIGH, 32'hFFFF, "snap_rst_mid");
    test_done();
  end
endmodule : tb
